// ==== pcgr_regs.sv ====
`timescale 1ns/1ps
// Function
// - Bit 19 of gate register 4 runs the comparator clock when one.
// - Bit 12 of gate register 4 runs serial port 2 clock when one.
// - Bit 11 of gate register 4 runs serial port 1 clock when one.
// - Bit 10 of gate register 4 runs serial port 0 clock when one.
// - Bit 7 of gate register 4 runs two-wire controller 1 clock.
// - Bit 6 of gate register 4 runs two-wire controller 0 clock.
// - Reserved bits 31..28 and 5..4 of gate register 4 are read-only ones.
// - Other reserved bits of both gate registers read as zero, bar bits 8,7,1 of register 5.
// - Bit 13 of gate register 5 runs port E clock, resets zero.
// - Gate register 5 sits at 1038h, reset bits 8,7,1 set.
// - Gate register 4 sits at offset 1034h.
module pcgr_regs (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic [pcgr_pkg::ADDR_W-1:0] addr_in,
  input wire logic [pcgr_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [pcgr_pkg::DATA_W-1:0] rdata_out,
  output logic comparator_gate_out,
  output logic async_serial_0_gate_out,
  output logic async_serial_1_gate_out,
  output logic async_serial_2_gate_out,
  output logic two_wire_0_gate_out,
  output logic two_wire_1_gate_out,
  output logic parallel_port_e_gate_out,
  output logic comparator_clk_out,
  output logic async_serial_0_clk_out,
  output logic async_serial_1_clk_out,
  output logic async_serial_2_clk_out,
  output logic two_wire_0_clk_out,
  output logic two_wire_1_clk_out,
  output logic parallel_port_e_clk_out
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic hit(
    input logic [pcgr_pkg::ADDR_W-1:0] addr,
    input logic [pcgr_pkg::ADDR_W-1:0] ofs
  );
    hit = (addr == ofs);
  endfunction : hit

  // Only writable bits take the bus value; fixed bits are forced every write.
  function automatic logic [pcgr_pkg::DATA_W-1:0] merge(
    input logic [pcgr_pkg::DATA_W-1:0] wdata,
    input logic [pcgr_pkg::DATA_W-1:0] wmask,
    input logic [pcgr_pkg::DATA_W-1:0] ones
  );
    merge = (wdata & wmask) | ones;
  endfunction : merge

  // ==========================================================================
  // State
  // ==========================================================================
  pcgr_pkg::pcgr_state_s state_ff;
  pcgr_pkg::pcgr_state_s nxt_state;
  logic hit4;
  logic hit5;
  logic [pcgr_pkg::N_GATES-1:0] gate_en;
  logic [pcgr_pkg::N_GATES-1:0] gate_clk;

  assign hit4 = hit(addr_in, pcgr_pkg::OFS_CTRL4);
  assign hit5 = hit(addr_in, pcgr_pkg::OFS_CTRL5);

  always_comb
  begin
    nxt_state = state_ff;
    // Read data is shown for one cycle only and is zero otherwise.
    nxt_state.rdata = pcgr_pkg::RD_IDLE;
    if (wr_in && hit4)
    begin
      nxt_state.ctrl4 = merge(wdata_in, pcgr_pkg::C4_WMASK, pcgr_pkg::C4_ONES);
    end
    if (wr_in && hit5)
    begin
      nxt_state.ctrl5 = merge(wdata_in, pcgr_pkg::C5_WMASK, pcgr_pkg::C5_ONES);
    end
    if (rd_in && hit4)
    begin
      nxt_state.rdata = state_ff.ctrl4;
    end
    else if (rd_in && hit5)
    begin
      nxt_state.rdata = state_ff.ctrl5;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_ff.ctrl4 <= pcgr_pkg::C4_RESET;
      state_ff.ctrl5 <= pcgr_pkg::C5_RESET;
      state_ff.rdata <= pcgr_pkg::RD_IDLE;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================================
  // Gate outputs
  // ==========================================================================
  assign gate_en[pcgr_pkg::IDX_COMPARATOR] = state_ff.ctrl4[pcgr_pkg::BIT_COMPARATOR];
  assign gate_en[pcgr_pkg::IDX_ASYNC_SERIAL_2] =
    state_ff.ctrl4[pcgr_pkg::BIT_ASYNC_SERIAL_2];
  assign gate_en[pcgr_pkg::IDX_ASYNC_SERIAL_1] =
    state_ff.ctrl4[pcgr_pkg::BIT_ASYNC_SERIAL_1];
  assign gate_en[pcgr_pkg::IDX_ASYNC_SERIAL_0] =
    state_ff.ctrl4[pcgr_pkg::BIT_ASYNC_SERIAL_0];
  assign gate_en[pcgr_pkg::IDX_TWO_WIRE_1] = state_ff.ctrl4[pcgr_pkg::BIT_TWO_WIRE_1];
  assign gate_en[pcgr_pkg::IDX_TWO_WIRE_0] = state_ff.ctrl4[pcgr_pkg::BIT_TWO_WIRE_0];
  assign gate_en[pcgr_pkg::IDX_PARALLEL_PORT_E] =
    state_ff.ctrl5[pcgr_pkg::BIT_PARALLEL_PORT_E];

  // One gate cell per peripheral; each stops its clock while its bit is zero.
  for (genvar g = 0; g < pcgr_pkg::N_GATES; g++)
  begin : gen_gate
    pcgr_clk_gate u_gate (
      .clk_in(ref_clk_in),
      .en_in(gate_en[g]),
      .gclk_out(gate_clk[g])
    );
  end

  assign rdata_out = state_ff.rdata;
  assign comparator_gate_out = gate_en[pcgr_pkg::IDX_COMPARATOR];
  assign async_serial_0_gate_out = gate_en[pcgr_pkg::IDX_ASYNC_SERIAL_0];
  assign async_serial_1_gate_out = gate_en[pcgr_pkg::IDX_ASYNC_SERIAL_1];
  assign async_serial_2_gate_out = gate_en[pcgr_pkg::IDX_ASYNC_SERIAL_2];
  assign two_wire_0_gate_out = gate_en[pcgr_pkg::IDX_TWO_WIRE_0];
  assign two_wire_1_gate_out = gate_en[pcgr_pkg::IDX_TWO_WIRE_1];
  assign parallel_port_e_gate_out = gate_en[pcgr_pkg::IDX_PARALLEL_PORT_E];
  assign comparator_clk_out = gate_clk[pcgr_pkg::IDX_COMPARATOR];
  assign async_serial_0_clk_out = gate_clk[pcgr_pkg::IDX_ASYNC_SERIAL_0];
  assign async_serial_1_clk_out = gate_clk[pcgr_pkg::IDX_ASYNC_SERIAL_1];
  assign async_serial_2_clk_out = gate_clk[pcgr_pkg::IDX_ASYNC_SERIAL_2];
  assign two_wire_0_clk_out = gate_clk[pcgr_pkg::IDX_TWO_WIRE_0];
  assign two_wire_1_clk_out = gate_clk[pcgr_pkg::IDX_TWO_WIRE_1];
  assign parallel_port_e_clk_out = gate_clk[pcgr_pkg::IDX_PARALLEL_PORT_E];

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rstn_in);

  a_comparator_gate: assert property (wr_in && hit4 |=>
    comparator_gate_out == $past(wdata_in[pcgr_pkg::BIT_COMPARATOR]))
    else $error("comparator gate did not follow the write");

  a_serial2_gate: assert property (wr_in && hit4 |=>
    async_serial_2_gate_out == $past(wdata_in[pcgr_pkg::BIT_ASYNC_SERIAL_2]))
    else $error("serial port 2 gate did not follow the write");

  a_serial1_gate: assert property (wr_in && hit4 |=>
    async_serial_1_gate_out == $past(wdata_in[pcgr_pkg::BIT_ASYNC_SERIAL_1]))
    else $error("serial port 1 gate did not follow the write");

  a_serial0_gate: assert property (wr_in && hit4 |=>
    async_serial_0_gate_out == $past(wdata_in[pcgr_pkg::BIT_ASYNC_SERIAL_0]))
    else $error("serial port 0 gate did not follow the write");

  a_two_wire1_gate: assert property (wr_in && hit4 |=>
    two_wire_1_gate_out == $past(wdata_in[pcgr_pkg::BIT_TWO_WIRE_1]))
    else $error("two-wire 1 gate did not follow the write");

  a_two_wire0_gate: assert property (wr_in && hit4 |=>
    two_wire_0_gate_out == $past(wdata_in[pcgr_pkg::BIT_TWO_WIRE_0]))
    else $error("two-wire 0 gate did not follow the write");

  a_ctrl4_ones: assert property (rd_in && hit4 |=>
    (rdata_out & pcgr_pkg::C4_ONES) == pcgr_pkg::C4_ONES)
    else $error("fixed-one bits of gate register 4 read wrong");

  a_reserved_zero: assert property (rd_in && (hit4 || hit5) |=>
    (rdata_out & ~(pcgr_pkg::C4_WMASK | pcgr_pkg::C4_ONES)
      & ~(pcgr_pkg::C5_WMASK | pcgr_pkg::C5_ONES)) == pcgr_pkg::RD_IDLE)
    else $error("reserved zero bits read as one");

  a_port_e_gate: assert property (wr_in && hit5 |=>
    parallel_port_e_gate_out == $past(wdata_in[pcgr_pkg::BIT_PARALLEL_PORT_E]))
    else $error("port E gate did not follow the write");

  a_ctrl5_read: assert property (rd_in && hit5 |=>
    rdata_out == (pcgr_pkg::C5_ONES
      | ({pcgr_pkg::DATA_W{$past(parallel_port_e_gate_out)}} & pcgr_pkg::C5_WMASK)))
    else $error("gate register 5 read value wrong");

  a_ctrl4_read: assert property (rd_in && hit4 |=>
    rdata_out[pcgr_pkg::BIT_COMPARATOR] == $past(comparator_gate_out)
    && rdata_out[pcgr_pkg::BIT_TWO_WIRE_0] == $past(two_wire_0_gate_out))
    else $error("gate register 4 read value wrong");

  a_fixed_stable: assert property (##1
    (state_ff.ctrl4 & ~pcgr_pkg::C4_WMASK) == pcgr_pkg::C4_ONES
    && (state_ff.ctrl5 & ~pcgr_pkg::C5_WMASK) == pcgr_pkg::C5_ONES)
    else $error("fixed bits of a gate register changed");

  a_stray_write: assert property (wr_in && !hit4 && !hit5 |=> $stable(gate_en))
    else $error("write to an unmapped address moved a gate");

  a_read_pulse: assert property (!rd_in |=> rdata_out == pcgr_pkg::RD_IDLE)
    else $error("read data held beyond one cycle");

  // Each register is checked against its own reserved set, so a bit that is
  // fixed in one register cannot hide a stray one in the other.
  a_ctrl4_zero: assert property (rd_in && hit4 |=>
    (rdata_out & ~(pcgr_pkg::C4_WMASK | pcgr_pkg::C4_ONES)) == pcgr_pkg::RD_IDLE)
    else $error("reserved zero bits of gate register 4 read as one");

  a_ctrl5_zero: assert property (rd_in && hit5 |=>
    (rdata_out & ~(pcgr_pkg::C5_WMASK | pcgr_pkg::C5_ONES)) == pcgr_pkg::RD_IDLE)
    else $error("reserved zero bits of gate register 5 read as one");

  a_ctrl4_hold: assert property (!(wr_in && hit4) |=> $stable(state_ff.ctrl4))
    else $error("gate register 4 changed without a write");

  a_ctrl5_hold: assert property (!(wr_in && hit5) |=> $stable(state_ff.ctrl5))
    else $error("gate register 5 changed without a write");

  a_unmapped_read: assert property (rd_in && !hit4 && !hit5 |=>
    rdata_out == pcgr_pkg::RD_IDLE)
    else $error("read of an unmapped address returned data");

  a_gate_hold: assert property (!wr_in |=> $stable(gate_en))
    else $error("a gate moved without any write");

  c_comparator_on: cover property (wr_in && hit4 ##1 comparator_gate_out);
  c_port_e_on: cover property (wr_in && hit5 ##1 parallel_port_e_gate_out);
  c_write_then_read: cover property (wr_in && hit4 ##1 rd_in && hit4);
  c_gate_off_again: cover property (two_wire_1_gate_out ##[1:20] !two_wire_1_gate_out);

endmodule : pcgr_regs

// ==== pcgr_pkg.sv ====
package pcgr_pkg;

  // ==========================================================================
  // Register bus geometry
  // ==========================================================================
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // Byte offsets of the two gating registers.
  localparam logic [ADDR_W-1:0] OFS_CTRL4 = 16'h1034;
  localparam logic [ADDR_W-1:0] OFS_CTRL5 = 16'h1038;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int BIT_COMPARATOR = 19;
  localparam int BIT_ASYNC_SERIAL_2 = 12;
  localparam int BIT_ASYNC_SERIAL_1 = 11;
  localparam int BIT_ASYNC_SERIAL_0 = 10;
  localparam int BIT_TWO_WIRE_1 = 7;
  localparam int BIT_TWO_WIRE_0 = 6;
  localparam int BIT_PARALLEL_PORT_E = 13;

  // Index of each peripheral in the internal gate vector.
  localparam int N_GATES = 7;
  localparam int IDX_COMPARATOR = 0;
  localparam int IDX_ASYNC_SERIAL_0 = 1;
  localparam int IDX_ASYNC_SERIAL_1 = 2;
  localparam int IDX_ASYNC_SERIAL_2 = 3;
  localparam int IDX_TWO_WIRE_0 = 4;
  localparam int IDX_TWO_WIRE_1 = 5;
  localparam int IDX_PARALLEL_PORT_E = 6;

  // ==========================================================================
  // Masks and reset values
  // ==========================================================================
  localparam logic [DATA_W-1:0] BIT_ONE = 32'h0000_0001;

  localparam logic [DATA_W-1:0] C4_WMASK = (BIT_ONE << BIT_COMPARATOR)
    | (BIT_ONE << BIT_ASYNC_SERIAL_2) | (BIT_ONE << BIT_ASYNC_SERIAL_1)
    | (BIT_ONE << BIT_ASYNC_SERIAL_0) | (BIT_ONE << BIT_TWO_WIRE_1)
    | (BIT_ONE << BIT_TWO_WIRE_0);
  // Reserved bits that always read as one: 31..28 and 5..4.
  localparam logic [DATA_W-1:0] C4_ONES = 32'hF000_0030;
  localparam logic [DATA_W-1:0] C4_RESET = C4_ONES;

  localparam logic [DATA_W-1:0] C5_WMASK = BIT_ONE << BIT_PARALLEL_PORT_E;
  // Reserved bits that always read as one: 8, 7 and 1.
  localparam logic [DATA_W-1:0] C5_ONES = 32'h0000_0182;
  localparam logic [DATA_W-1:0] C5_RESET = C5_ONES;

  localparam logic [DATA_W-1:0] RD_IDLE = 32'h0000_0000;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [DATA_W-1:0] ctrl4;
    logic [DATA_W-1:0] ctrl5;
    logic [DATA_W-1:0] rdata;
  } pcgr_state_s;

endpackage : pcgr_pkg

// ==== pcgr_clk_gate.sv ====
`timescale 1ns/1ps
module pcgr_clk_gate (
  input wire logic clk_in,
  input wire logic en_in,
  output logic gclk_out
);

  // ==========================================================================
  // Glitch-free gate
  // ==========================================================================
  // The enable is only allowed to change while the clock is low, so a
  // register write in mid-cycle can never clip a high phase.
  logic en_lat;

  always_latch
  begin
    if (!clk_in)
    begin
      en_lat <= en_in;
    end
  end

  assign gclk_out = clk_in & en_lat;

endmodule : pcgr_clk_gate

// ==== tb_pcgr_regs.sv ====
`timescale 1ns/1ps
module tb_pcgr_regs;
  // ==========================================================================
  // Stimulus and observation
  // ==========================================================================
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [pcgr_pkg::ADDR_W-1:0] addr_in = 16'h0000;
  logic [pcgr_pkg::DATA_W-1:0] wdata_in = 32'h0000_0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [pcgr_pkg::DATA_W-1:0] rdata_out;
  wire logic [6:0] gates;
  wire logic [6:0] clks;
  int miscompares = 0;
  int checks_done = 0;

  pcgr_regs i_dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .comparator_gate_out(gates[0]), .async_serial_0_gate_out(gates[1]),
    .async_serial_1_gate_out(gates[2]), .async_serial_2_gate_out(gates[3]),
    .two_wire_0_gate_out(gates[4]), .two_wire_1_gate_out(gates[5]),
    .parallel_port_e_gate_out(gates[6]), .comparator_clk_out(clks[0]),
    .async_serial_0_clk_out(clks[1]), .async_serial_1_clk_out(clks[2]),
    .async_serial_2_clk_out(clks[3]), .two_wire_0_clk_out(clks[4]),
    .two_wire_1_clk_out(clks[5]), .parallel_port_e_clk_out(clks[6]));

  initial
  begin
    forever #4 ref_clk_in = ~ref_clk_in;
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic bus_wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask : bus_rd

  // Reads both registers and checks gate levels and gated clock phases
  // against what was last written to each register.
  task automatic reg_check(input logic [31:0] w4, input logic [31:0] w5);
    logic [31:0] d;
    logic [6:0] g;
    g = {w5[13], w4[7], w4[6], w4[12], w4[11], w4[10], w4[19]};
    bus_rd(16'h1034, d);
    check("ctrl4 read", d, 32'hF000_0030 | (w4 & 32'h0008_1CC0));
    bus_rd(16'h1038, d);
    check("ctrl5 read", d, 32'h0000_0182 | (w5 & 32'h0000_2000));
    check("gate levels", {25'h0, gates}, {25'h0, g});
    @(posedge ref_clk_in);
    #2 check("clocks high phase", {25'h0, clks}, {25'h0, g});
    #4 check("clocks low phase", {25'h0, clks}, 32'h0000_0000);
  endtask : reg_check

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_walk;
    int pos [6] = '{19, 12, 11, 10, 7, 6};
    foreach (pos[i])
    begin
      bus_wr(16'h1034, 32'h0000_0001 << pos[i]);
      reg_check(32'h0000_0001 << pos[i], 32'h0000_0000);
    end
    bus_wr(16'h1038, 32'h0000_2000);
    reg_check(32'h0000_0040, 32'h0000_2000);
    $display("test walk done");
  endtask : t_walk

  task automatic t_reserved;
    bus_wr(16'h1034, 32'hFFFF_FFFF);
    bus_wr(16'h1038, 32'hFFFF_FFFF);
    reg_check(32'hFFFF_FFFF, 32'hFFFF_FFFF);
    bus_wr(16'h1034, 32'h0000_0000);
    bus_wr(16'h1038, 32'h0000_0000);
    reg_check(32'h0000_0000, 32'h0000_0000);
    $display("test reserved done");
  endtask : t_reserved

  task automatic t_unmapped;
    logic [15:0] bad [3] = '{16'h1030, 16'h103C, 16'h1036};
    logic [31:0] d;
    bus_wr(16'h1034, 32'h0008_1CC0);
    foreach (bad[i])
    begin
      bus_wr(bad[i], 32'h0000_0000);
      bus_rd(bad[i], d);
      check("unmapped read", d, 32'h0000_0000);
    end
    reg_check(32'h0008_1CC0, 32'h0000_0000);
    // A read issued in the cycle right after a write sees the new value.
    @(posedge ref_clk_in);
    addr_in <= 16'h1038;
    wdata_in <= 32'h0000_2000;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1 check("read after write", rdata_out, 32'h0000_2182);
    @(posedge ref_clk_in);
    #1 check("read data idle", rdata_out, 32'h0000_0000);
    $display("test unmapped done");
  endtask : t_unmapped

  task automatic t_reset_mid;
    @(posedge ref_clk_in);
    rstn_in <= 1'b0;
    #1 check("gates in reset", {25'h0, gates}, 32'h0000_0000);
    repeat (2) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    reg_check(32'h0000_0000, 32'h0000_0000);
    $display("test mid reset done");
  endtask : t_reset_mid

  initial
  begin
    repeat (16) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    reg_check(32'h0000_0000, 32'h0000_0000);
    $display("test reset values done");
    t_walk();
    t_reserved();
    t_unmapped();
    t_reset_mid();
    wrap_up();
  end

  // The whole run is about 120 cycles; this bound only catches a hang.
  initial
  begin
    repeat (5000) @(posedge ref_clk_in);
    miscompares++;
    wrap_up();
  end
endmodule : tb_pcgr_regs
